// *** common/pcg_defs.svh ***
// Offsets, field positions, reset values and counts of the clock generator control block
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PCG_OFS_CONTROL 8'h00
`define PCG_OFS_BANDWIDTH 8'h04
`define PCG_OFS_PROGRAMMING 8'h08

// ****************************************
// Field positions
// ****************************************
`define PCG_CTL_IRQ_EN 7
`define PCG_CTL_FLAG 6
`define PCG_CTL_PLL_ON 5
`define PCG_CTL_BCS 4
`define PCG_BW_AUTO 7
`define PCG_BW_LOCK 6
`define PCG_BW_ACQ 5
`define PCG_BW_XLD 4
`define PCG_PRG_MUL_HI 7
`define PCG_PRG_MUL_LO 4
`define PCG_PRG_VRS_HI 3
`define PCG_PRG_VRS_LO 0

// ****************************************
// Reset values and fixed read values
// ****************************************
`define PCG_CTL_LOW_ONES 4'hF
`define PCG_MUL_RESET 4'h6
`define PCG_VRS_RESET 4'h6

// ****************************************
// Counts
// ****************************************
`define PCG_SWITCH_EDGES 2'h3
`define PCG_XLD_CYCLES_PER_N 4

`endif

// *** common/pcg_pkg.sv ***
// Types shared by the clock generator control block
package pcg_pkg;

    // Base clock selector state
    typedef enum logic {
        SEL_STEADY,
        SEL_SWITCH
    } pcg_sel_state_t;

    // AHB-Lite transfer types
    typedef enum logic [1:0] {
        HT_IDLE = 2'h0,
        HT_BUSY = 2'h1,
        HT_NONSEQ = 2'h2,
        HT_SEQ = 2'h3
    } pcg_htrans_t;

endpackage

// *** logic/pcg_clock_gen.sv ***
// Clock generator control: registers, lock interrupt, glitch-free base clock selector
// Operation
// [R1] Interrupt enable ignores writes and reads 0 in manual mode; reset clears it.
// [R2] Lock toggle sets lock-change flag; flag with enable drives interrupt output.
// [R3] Lock-change flag reads 0 in manual mode; reset clears it.
// [R4] Any read of control register clears the lock-change flag.
// [R5] Loop-on enables PLL and VCO; clearing refused while VCO is base source.
// [R6] Reset sets loop-on so the loop stabilises at power up.
// [R7] Select bit 1 picks VCO/2, 0 crystal/2; setting refused while loop off.
// [R8] After select change, hold base clock until three crystal and three VCO edges; code skips the VCO count while the loop is off.
// [R9] Reset and stop clear select bit, returning to crystal source.
// [R10] Control register low four bits read as ones.
// [R11] Bandwidth mode bit: 1 automatic, 0 manual; reset clears it.
// [R12] Lock bit read-only, 1 when locked in automatic mode, 0 in manual.
// [R13] Acquisition bit: status in automatic, control in manual; 1 tracking; reset 0.
// [R14] Manual acquisition value is kept during automatic mode and restored after.
// [R15] Write 1 to crystal-loss bit, wait N*4, read: 1 inactive, 0 active.
// [R16] Crystal-loss detection only with VCO selected; reads 0 while select clear.
// [R17] Software writes zeros to bandwidth register low test bits.
// [R18] Upper programming bits set multiplier 1..15; code 0 acts as 1.
// [R19] Reset sets multiplier and VCO range fields to 6.
// [R20] Multiplier and range fields ignore writes while loop-on is set.
// [R21] Range zero disables PLL, clears select bit, refuses VCO selection.
// [R22] Base clock is 50% duty, half the selected source frequency.
// [R23] Oscillator enable low disables block; crystal, base, interrupt outputs low.
// [R24] Lock toggle in same cycle as control read: setting the flag wins.
`timescale 1ns/1ns
`include "pcg_defs.svh"

module pcg_clock_gen
(
    input wire logic clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock sources and analog status, sampled on clk
    input wire logic xtalIn,
    input wire logic vcoIn,
    input wire logic lockIn,
    input wire logic trackIn,
    input wire logic systemOscEnable,
    // Outputs toward the loop and the system
    output logic crystalClock,
    output logic baseClockOut,
    output logic lockIrqOut,
    output logic loopEnable,
    output logic trackingMode,
    output logic [3:0] feedbackMultiplier,
    output logic [3:0] vcoRange
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic addrTake;
    logic [7:0] addrPh_reg;
    logic wrPh_reg;
    logic rdPh_reg;
    logic wrCtl;
    logic wrBw;
    logic wrPrg;
    logic rdCtlNow;

    // Address phase is taken only on NONSEQ/SEQ with the bus ready
    assign addrTake = hsel && hready && htrans[1];
    assign wrCtl = wrPh_reg && (addrPh_reg == `PCG_OFS_CONTROL);
    assign wrBw = wrPh_reg && (addrPh_reg == `PCG_OFS_BANDWIDTH);
    assign wrPrg = wrPh_reg && (addrPh_reg == `PCG_OFS_PROGRAMMING);
    // Control read side effect lands in the data cycle that captures hrdata
    assign rdCtlNow = rdPh_reg && !hreadyout && (addrPh_reg == `PCG_OFS_CONTROL);

    // ****************************************
    // Register state
    // ****************************************
    logic irqEn_reg;
    logic flag_reg;
    logic loop_power_on_reg;
    logic bcs_reg;
    logic auto_reg;
    logic lock_reg;
    logic acqManual_reg;
    logic xld_reg;
    logic [3:0] mul_reg;
    logic [3:0] vrs_reg;
    logic xtalPrev_reg;
    logic vcoPrev_reg;
    logic xtalRise;
    logic vcoRise;
    logic lockNext;
    logic vcoLive;

    assign xtalRise = xtalIn && !xtalPrev_reg;
    assign vcoRise = vcoIn && !vcoPrev_reg;
    // Range zero keeps the loop off whatever loop-on says
    assign vcoLive = loop_power_on_reg && (vrs_reg != 4'h0); // see [R21]
    // Lock status means nothing in manual mode or with the loop off
    assign lockNext = auto_reg && vcoLive && lockIn; // see [R12]

    // Address/data phase tracking and zero-wait writes, one-wait reads
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            addrPh_reg <= 8'h00;
            wrPh_reg <= 1'b0;
            rdPh_reg <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (hreadyout)
        begin
            addrPh_reg <= haddr;
            wrPh_reg <= addrTake && hwrite;
            rdPh_reg <= addrTake && !hwrite;
            hreadyout <= !(addrTake && !hwrite); // Reads stall one cycle
        end
        else
        begin
            hreadyout <= 1'b1;
            rdPh_reg <= 1'b0;
        end
    end

    // Read data is built in the wait cycle so a preceding write is already visible
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (rdPh_reg && !hreadyout)
        begin
            hrdata <= 32'h0000_0000;
            unique case (addrPh_reg)
                `PCG_OFS_CONTROL:
                    hrdata[7:0] <= {irqEn_reg && auto_reg, // see [R1]
                                    flag_reg && auto_reg, // see [R3]
                                    loop_power_on_reg, bcs_reg,
                                    `PCG_CTL_LOW_ONES}; // see [R10]
                `PCG_OFS_BANDWIDTH:
                    hrdata[7:0] <= {auto_reg, lock_reg,
                                    auto_reg ? trackIn : acqManual_reg, // see [R13]
                                    xld_reg && bcs_reg, // see [R16]
                                    4'h0};
                `PCG_OFS_PROGRAMMING:
                    hrdata[7:0] <= {mul_reg, vrs_reg};
                default:
                    hrdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    // Interrupt enable writes count only in automatic mode
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irqEn_reg <= 1'b0; // see [R1]
        end
        else if (wrCtl && auto_reg)
        begin
            irqEn_reg <= hwdata[`PCG_CTL_IRQ_EN]; // see [R1]
        end
    end

    // Lock-change flag: a toggle wins over the read that clears it
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            flag_reg <= 1'b0; // see [R3]
        end
        else if (auto_reg && (lockNext != lock_reg))
        begin
            flag_reg <= 1'b1; // see [R2] see [R24]
        end
        else if (rdCtlNow)
        begin
            flag_reg <= 1'b0; // see [R4]
        end
    end

    // Loop on: cannot drop while the VCO is the base source
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            loop_power_on_reg <= 1'b1; // see [R6]
        end
        else if (wrCtl)
        begin
            loop_power_on_reg <= hwdata[`PCG_CTL_PLL_ON] || bcs_reg; // see [R5]
        end
    end

    // Base select: set needs the loop already on, so from loop off VCO selection takes two writes
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            bcs_reg <= 1'b0; // see [R9]
        end
        else if (!systemOscEnable || (vrs_reg == 4'h0))
        begin
            bcs_reg <= 1'b0; // see [R9] see [R21]
        end
        else if (wrCtl)
        begin
            bcs_reg <= hwdata[`PCG_CTL_BCS] && loop_power_on_reg; // see [R7]
        end
    end

    // ****************************************
    // Bandwidth control register
    // ****************************************
    // Mode bit and the manual acquisition value kept across automatic periods
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            auto_reg <= 1'b0; // see [R11]
            acqManual_reg <= 1'b0; // see [R13]
        end
        else if (wrBw)
        begin
            auto_reg <= hwdata[`PCG_BW_AUTO]; // see [R11]
            if (!auto_reg)
            begin
                acqManual_reg <= hwdata[`PCG_BW_ACQ]; // see [R14]
            end
        end
    end

    // Lock indicator follows the loop only in automatic mode
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            lock_reg <= 1'b0;
        end
        else
        begin
            lock_reg <= lockNext; // see [R12]
        end
    end

    // Crystal loss: armed by writing 1, any crystal rising edge proves the reference alive.
    // Software waits N*4 cycles; edges come far faster, so no counter is kept here.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            xld_reg <= 1'b0;
        end
        else if (!bcs_reg)
        begin
            xld_reg <= 1'b0; // see [R16]
        end
        else if (wrBw && hwdata[`PCG_BW_XLD])
        begin
            xld_reg <= 1'b1; // see [R15]
        end
        else if (xtalRise)
        begin
            xld_reg <= 1'b0; // see [R15]
        end
    end

    // ****************************************
    // Programming register
    // ****************************************
    // Fields locked while the loop runs
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mul_reg <= `PCG_MUL_RESET; // see [R19]
            vrs_reg <= `PCG_VRS_RESET; // see [R19]
        end
        else if (wrPrg && !loop_power_on_reg)
        begin
            mul_reg <= hwdata[`PCG_PRG_MUL_HI:`PCG_PRG_MUL_LO]; // see [R20]
            vrs_reg <= hwdata[`PCG_PRG_VRS_HI:`PCG_PRG_VRS_LO]; // see [R20]
        end
    end

    // ****************************************
    // Base clock selector
    // ****************************************
    pcg_pkg::pcg_sel_state_t selState_reg;
    logic curSrc_reg;
    logic [1:0] xtalCnt_reg;
    logic [1:0] vcoCnt_reg;
    logic xtalDone;
    logic vcoDone;
    logic srcRise;

    assign xtalDone = (xtalCnt_reg == `PCG_SWITCH_EDGES);
    // A stopped VCO would hang the switch, so it counts as done when the loop is off
    assign vcoDone = (vcoCnt_reg == `PCG_SWITCH_EDGES) || !vcoLive;
    assign srcRise = curSrc_reg ? vcoRise : xtalRise;

    // Edge history of both sources
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            xtalPrev_reg <= 1'b0;
            vcoPrev_reg <= 1'b0;
        end
        else
        begin
            xtalPrev_reg <= xtalIn;
            vcoPrev_reg <= vcoIn;
        end
    end

    // Transition control: hold output static across the edge counts
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            selState_reg <= pcg_pkg::SEL_STEADY;
            curSrc_reg <= 1'b0;
            xtalCnt_reg <= 2'h0;
            vcoCnt_reg <= 2'h0;
        end
        else
        begin
            unique case (selState_reg)
                pcg_pkg::SEL_STEADY:
                begin
                    xtalCnt_reg <= 2'h0;
                    vcoCnt_reg <= 2'h0;
                    if (bcs_reg != curSrc_reg)
                    begin
                        selState_reg <= pcg_pkg::SEL_SWITCH; // see [R8]
                    end
                end
                pcg_pkg::SEL_SWITCH:
                begin
                    if (xtalRise && !xtalDone)
                    begin
                        xtalCnt_reg <= xtalCnt_reg + 2'h1; // see [R8]
                    end
                    if (vcoRise && (vcoCnt_reg != `PCG_SWITCH_EDGES))
                    begin
                        vcoCnt_reg <= vcoCnt_reg + 2'h1; // see [R8]
                    end
                    if (xtalDone && vcoDone)
                    begin
                        curSrc_reg <= bcs_reg; // see [R8]
                        selState_reg <= pcg_pkg::SEL_STEADY;
                    end
                end
            endcase
        end
    end

    // Divide by two on each source rise gives 50% duty; held during a switch
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            baseClockOut <= 1'b0;
        end
        else if (!systemOscEnable)
        begin
            baseClockOut <= 1'b0; // see [R23]
        end
        else if ((selState_reg == pcg_pkg::SEL_STEADY) && srcRise)
        begin
            baseClockOut <= !baseClockOut; // see [R22] see [R7]
        end
    end

    // ****************************************
    // System outputs
    // ****************************************
    // All outputs registered; stop forces the clocks and interrupt low
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            crystalClock <= 1'b0;
            lockIrqOut <= 1'b0;
            loopEnable <= 1'b0;
            trackingMode <= 1'b0;
            feedbackMultiplier <= 4'h1;
            vcoRange <= `PCG_VRS_RESET;
        end
        else
        begin
            crystalClock <= xtalIn && systemOscEnable; // see [R23]
            lockIrqOut <= flag_reg && irqEn_reg && auto_reg && systemOscEnable; // see [R2]
            loopEnable <= vcoLive && systemOscEnable; // see [R5] see [R21]
            trackingMode <= auto_reg ? trackIn : acqManual_reg; // see [R13]
            feedbackMultiplier <= (mul_reg == 4'h0) ? 4'h1 : mul_reg; // see [R18]
            vcoRange <= vrs_reg;
        end
    end

endmodule

// *** tb/pcg_far_side.sv ***
// Behavioural model of the crystal, the VCO and the system oscillator enable
`timescale 1ns/1ns

module pcg_far_side
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic loopEnable,
    input wire logic xtalRun,
    input wire logic stopReq,
    output logic xtalIn,
    output logic vcoIn,
    output logic systemOscEnable
);
    logic [1:0] xtalCnt_reg;
    logic vcoCnt_reg;

    // Crystal toggles every third cycle; a dead crystal sits low
    always_ff @(posedge clk)
    begin
        if (!nrst || !xtalRun)
        begin
            xtalCnt_reg <= 2'h0;
            xtalIn <= 1'b0;
        end
        else if (xtalCnt_reg == 2'h2)
        begin
            xtalCnt_reg <= 2'h0;
            xtalIn <= !xtalIn;
        end
        else
            xtalCnt_reg <= xtalCnt_reg + 2'h1;
    end

    // VCO runs only while the loop is enabled, so a wrongly gated loop shows up
    always_ff @(posedge clk)
    begin
        if (!nrst || !loopEnable)
        begin
            vcoCnt_reg <= 1'b0;
            vcoIn <= 1'b0;
        end
        else
        begin
            vcoCnt_reg <= !vcoCnt_reg;
            if (vcoCnt_reg)
                vcoIn <= !vcoIn;
        end
    end

    // Oscillator enable drops while a stop is requested
    always_ff @(posedge clk)
    begin
        systemOscEnable <= !nrst || !stopReq;
    end
endmodule

// *** tb/pcg_clock_gen_props.sv ***
// Port-level assertions of the clock generator control block
`timescale 1ns/1ns

module pcg_clock_gen_props
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic xtalIn,
    input wire logic systemOscEnable,
    input wire logic crystalClock,
    input wire logic baseClockOut,
    input wire logic lockIrqOut,
    input wire logic loopEnable,
    input wire logic [3:0] feedbackMultiplier,
    input wire logic [3:0] vcoRange
);
    logic taken;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // A transfer is accepted only when the slave is ready
    assign taken = hsel & hready & htrans[1] & hreadyout;

    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    a_stop_quiet: assert property (!systemOscEnable |=>
        !crystalClock && !baseClockOut && !lockIrqOut && !loopEnable)
        else $error("outputs active in stop");
    a_xtal_follow: assert property (systemOscEnable |=> crystalClock == $past(xtalIn))
        else $error("crystal clock not passed on");
    a_mul_nonzero: assert property (feedbackMultiplier != 4'h0)
        else $error("multiplier zero");
    a_loop_gate: assert property (loopEnable |-> vcoRange != 4'h0 && $past(systemOscEnable))
        else $error("loop on with range zero or in stop");
    a_field_guard: assert property ($changed(vcoRange) || $changed(feedbackMultiplier)
        |-> !$past(loopEnable)) else $error("fields changed with loop on");

    c_read: cover property (taken && !hwrite);
    c_irq: cover property ($rose(lockIrqOut));
    c_stop: cover property ($fell(systemOscEnable));
endmodule

bind pcg_clock_gen pcg_clock_gen_props u_props (.clk(clk), .nrst(nrst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .xtalIn(xtalIn), .systemOscEnable(systemOscEnable),
    .crystalClock(crystalClock), .baseClockOut(baseClockOut), .lockIrqOut(lockIrqOut),
    .loopEnable(loopEnable), .feedbackMultiplier(feedbackMultiplier), .vcoRange(vcoRange));

// *** tb/pcg_clock_gen_bench.sv ***
// Self-checking bench of the clock generator control block
`timescale 1ns/1ns
`include "pcg_defs.svh"

module pcg_clock_gen_bench;
    logic clk, nrst, hsel, hwrite, lockIn, trackIn, xtalRun, stopReq;
    logic xtalIn, vcoIn, systemOscEnable, hreadyout, hresp, crystalClock, baseClockOut;
    logic lockIrqOut, loopEnable, trackingMode;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] feedbackMultiplier, vcoRange;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    pcg_clock_gen dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .xtalIn(xtalIn), .vcoIn(vcoIn), .lockIn(lockIn),
        .trackIn(trackIn), .systemOscEnable(systemOscEnable), .crystalClock(crystalClock),
        .baseClockOut(baseClockOut), .lockIrqOut(lockIrqOut), .loopEnable(loopEnable),
        .trackingMode(trackingMode), .feedbackMultiplier(feedbackMultiplier),
        .vcoRange(vcoRange));
    pcg_far_side far (.clk(clk), .nrst(nrst), .loopEnable(loopEnable), .xtalRun(xtalRun),
        .stopReq(stopReq), .xtalIn(xtalIn), .vcoIn(vcoIn), .systemOscEnable(systemOscEnable));

    // ****************************************
    // Clock, timeout and report
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end

    // Bus waits have no bound of their own, so this ceiling catches a hung slave
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            finish_test();
        end
    end

    task finish_test();
        $display("comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // ****************************************
    // AHB-Lite master tasks
    // ****************************************
    // Address phase held until hready is seen high
    task bus_addr(input logic [7:0] a, input logic w);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= pcg_pkg::HT_NONSEQ;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= pcg_pkg::HT_IDLE;
        hsel <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr(a, 1'b1);
        hwdata <= {24'h0, d}; // Register sits in the low byte
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        bus_addr(a, 1'b0);
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        chk(hrdata, {24'h0, exp});
    endtask

    // Counts base clock changes over n cycles
    task count_base(input int n, input logic [31:0] exp);
        logic last;
        int k;
        k = 0;
        @(posedge clk);
        last = baseClockOut;
        repeat (n)
        begin
            @(posedge clk);
            if (baseClockOut !== last)
                k++;
            last = baseClockOut;
        end
        chk(k, exp);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        {nrst, hsel, hwrite, lockIn, trackIn, stopReq} = 6'h00;
        {haddr, htrans, hwdata} = 42'h0;
        hsize = 3'h2;
        xtalRun = 1'b1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(`PCG_OFS_CONTROL, 8'h2F);
        rd(`PCG_OFS_BANDWIDTH, 8'h00);
        rd(`PCG_OFS_PROGRAMMING, 8'h66);
        wr(`PCG_OFS_PROGRAMMING, 8'h35);
        rd(`PCG_OFS_PROGRAMMING, 8'h66);
        chk(feedbackMultiplier, 32'h6);
        wr(`PCG_OFS_CONTROL, 8'h00);
        wr(`PCG_OFS_CONTROL, 8'h10);
        rd(`PCG_OFS_CONTROL, 8'h0F);
        chk(loopEnable, 32'h0);
        wr(`PCG_OFS_PROGRAMMING, 8'h00);
        rd(`PCG_OFS_PROGRAMMING, 8'h00);
        chk(feedbackMultiplier, 32'h1);
        chk(vcoRange, 32'h0);
        wr(`PCG_OFS_CONTROL, 8'h20);
        wr(`PCG_OFS_CONTROL, 8'h30);
        rd(`PCG_OFS_CONTROL, 8'h2F);
        chk(loopEnable, 32'h0);
        wr(`PCG_OFS_CONTROL, 8'h00);
        wr(`PCG_OFS_PROGRAMMING, 8'h36);
        wr(`PCG_OFS_CONTROL, 8'h20);
        wr(`PCG_OFS_CONTROL, 8'h30);
        rd(`PCG_OFS_CONTROL, 8'h3F);
        wr(`PCG_OFS_CONTROL, 8'h00);
        rd(`PCG_OFS_CONTROL, 8'h2F);
        // Lock events in automatic mode
        wr(`PCG_OFS_BANDWIDTH, 8'h80);
        wr(`PCG_OFS_CONTROL, 8'hA0);
        rd(`PCG_OFS_CONTROL, 8'hAF);
        lockIn <= 1'b1;
        repeat (8) @(posedge clk);
        chk(lockIrqOut, 32'h1);
        rd(`PCG_OFS_BANDWIDTH, 8'hC0);
        rd(`PCG_OFS_CONTROL, 8'hEF);
        rd(`PCG_OFS_CONTROL, 8'hAF);
        repeat (2) @(posedge clk);
        chk(lockIrqOut, 32'h0);
        lockIn <= 1'b0;
        repeat (8) @(posedge clk);
        wr(`PCG_OFS_BANDWIDTH, 8'h00);
        rd(`PCG_OFS_CONTROL, 8'h2F);
        chk(lockIrqOut, 32'h0);
        // Manual acquisition value survives automatic mode; the switching write
        // is itself a manual-mode write, so it carries the acquisition bit along
        wr(`PCG_OFS_BANDWIDTH, 8'h20);
        rd(`PCG_OFS_BANDWIDTH, 8'h20);
        chk(trackingMode, 32'h1);
        wr(`PCG_OFS_BANDWIDTH, 8'hA0);
        rd(`PCG_OFS_BANDWIDTH, 8'h80);
        trackIn <= 1'b1;
        rd(`PCG_OFS_BANDWIDTH, 8'hA0);
        trackIn <= 1'b0;
        wr(`PCG_OFS_BANDWIDTH, 8'h00);
        rd(`PCG_OFS_BANDWIDTH, 8'h20);
        // Crystal loss test with the VCO driving the base clock, N = 3
        wr(`PCG_OFS_CONTROL, 8'h30);
        repeat (30) @(posedge clk);
        count_base(40, 32'd10);
        xtalRun <= 1'b0;
        wr(`PCG_OFS_BANDWIDTH, 8'h10);
        repeat (12) @(posedge clk);
        rd(`PCG_OFS_BANDWIDTH, 8'h10);
        xtalRun <= 1'b1;
        wr(`PCG_OFS_BANDWIDTH, 8'h10);
        repeat (12) @(posedge clk);
        rd(`PCG_OFS_BANDWIDTH, 8'h00);
        // Stop instruction
        stopReq <= 1'b1;
        repeat (4) @(posedge clk);
        chk({crystalClock, baseClockOut, lockIrqOut}, 32'h0);
        stopReq <= 1'b0;
        rd(`PCG_OFS_CONTROL, 8'h2F);
        wr(`PCG_OFS_BANDWIDTH, 8'h10);
        rd(`PCG_OFS_BANDWIDTH, 8'h00);
        repeat (30) @(posedge clk);
        count_base(36, 32'd6);
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h00);
        finish_test();
    end
endmodule
